// File: vram_ctl_pkg.sv
// package: register map, commands and pin levels of the video dram controller
package vram_ctl_pkg;
   localparam int AW = 9;
   localparam int DW = 4;
   localparam int CLK_PERIOD_NS = 100;
   localparam int ROW_OPEN_MAX_NS = 100000;
   localparam int ROW_OPEN_CYC = ROW_OPEN_MAX_NS / CLK_PERIOD_NS;
   localparam int ROW_GUARD_CYC = 16;
   localparam logic [9:0] ROW_LIMIT = 10'(ROW_OPEN_CYC - ROW_GUARD_CYC);
   localparam logic [2:0] READ_WAIT = 3'h4;
   localparam logic [2:0] SER_WAIT = 3'h3;
   // register byte addresses
   localparam logic [7:0] A_CMD = 8'h00;
   localparam logic [7:0] A_ADDR = 8'h04;
   localparam logic [7:0] A_WDATA = 8'h08;
   localparam logic [7:0] A_STAT = 8'h0C;
   localparam logic [7:0] A_SER = 8'h10;
   // field positions
   localparam int CMD_KEEP = 4;
   localparam int ADDR_COL = 16;
   localparam int WD_MASK = 4;
   localparam int ST_BUSY = 8;
   localparam int ST_OPEN = 9;
   localparam int ST_SDIR = 10;
   localparam int ST_HALF = 11;
   localparam int ST_ERR = 12;
   localparam int SER_EN = 4;
   localparam int SER_BUSY = 8;
   localparam logic [31:0] RST_ZERO = 32'h0;

   typedef enum logic [3:0] {
      OP_READ, OP_WRITE, OP_MASK_WRITE, OP_BLOCK_WRITE, OP_MASK_BLOCK_WRITE,
      OP_FLASH_WRITE, OP_COLOR_READ, OP_COLOR_WRITE, OP_RMW, OP_READ_XFER,
      OP_SPLIT_READ_XFER, OP_WRITE_XFER, OP_SPLIT_WRITE_XFER,
      OP_PSEUDO_XFER, OP_REFRESH
   } op_t;

   // levels at the row strobe fall: {xfer_oe_n, we_n, se_n, flag}
   function automatic logic [3:0] ras_levels(op_t op);
      case (op)
         OP_MASK_WRITE, OP_MASK_BLOCK_WRITE: ras_levels = 4'hA;
         OP_FLASH_WRITE:                     ras_levels = 4'hB;
         OP_COLOR_READ, OP_COLOR_WRITE:      ras_levels = 4'hF;
         OP_READ_XFER:                       ras_levels = 4'h6;
         OP_SPLIT_READ_XFER:                 ras_levels = 4'h7;
         OP_WRITE_XFER:                      ras_levels = 4'h0;
         OP_PSEUDO_XFER:                     ras_levels = 4'h2;
         OP_SPLIT_WRITE_XFER:                ras_levels = 4'h3;
         default:                            ras_levels = 4'hE;
      endcase
   endfunction

   function automatic logic is_block(op_t op);
      is_block = (op == OP_BLOCK_WRITE) || (op == OP_MASK_BLOCK_WRITE);
   endfunction

   function automatic logic is_rd(op_t op);
      is_rd = (op == OP_READ) || (op == OP_COLOR_READ) || (op == OP_RMW);
   endfunction

   function automatic logic is_xfer(op_t op);
      is_xfer = (op >= OP_READ_XFER) && (op <= OP_PSEUDO_XFER);
   endfunction

   function automatic logic is_page(op_t op);
      is_page = (op <= OP_MASK_BLOCK_WRITE) || (op == OP_RMW);
   endfunction

   // byte-lane merge for bus writes
   function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw,
                                         logic [3:0] sel);
      merge = old;
      for (int i = 0; i < 4; i++)
         if (sel[i])
            merge[i*8 +: 8] = nw[i*8 +: 8];
   endfunction
endpackage

// File: vram_pin_sync.sv
// three-stage synchroniser for pin inputs, output follows agreeing stages
`timescale 1ns/100ps
module vram_pin_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] level
);
   import vram_ctl_pkg::*;

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } sync_t;

   sync_t q;
   sync_t d;

   always_comb
   begin
      d = q;
      d.s1 = pin;
      d.s2 = q.s1;
      d.s3 = q.s2;
      if (q.s2 == q.s3)
         d.lvl = q.s3;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         q <= '0;
      else
         q <= d;
   end

   assign level = q.lvl;
endmodule

// File: vram_serial.sv
// serial buffer port: one shift clock pulse per request, word out or in
`timescale 1ns/100ps
module vram_serial (
   input  wire logic                       clk,
   input  wire logic                       sys_rst,
   input  wire logic                       go,
   input  wire logic [vram_ctl_pkg::DW-1:0] word,
   input  wire logic                       en,
   input  wire logic                       host_drives,
   input  wire logic                       force_se_low,
   input  wire logic [vram_ctl_pkg::DW-1:0] sdq_sense,
   output logic                            serial_shift_clock,
   output logic                            serial_port_enable_n,
   output logic      [vram_ctl_pkg::DW-1:0] sdq_drv,
   output logic                            sdq_oe_n,
   output logic      [vram_ctl_pkg::DW-1:0] rx,
   output logic                            busy
);
   import vram_ctl_pkg::*;

   typedef enum logic [2:0] {SR_IDLE, SR_SET, SR_HI, SR_LO, SR_WAIT} sst_t;

   typedef struct packed {
      sst_t          st;
      logic [2:0]    cnt;
      logic          sck;
      logic          se_n;
      logic [DW-1:0] drv;
      logic          oe_n;
      logic [DW-1:0] rx;
   } ser_t;

   ser_t          q;
   ser_t          d;
   logic [DW-1:0] sense;

   vram_pin_sync #(.W(DW)) u_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .pin     (sdq_sense),
      .level   (sense)
   );

   always_comb
   begin
      d = q;
      case (q.st)
         SR_IDLE:
            if (go)
            begin
               // disabled port: device ignores the word, pointer still steps
               d.se_n = !en;
               d.drv = word;
               d.oe_n = !(host_drives && en);
               d.st = SR_SET;
            end
         SR_SET:
         begin
            d.sck = 1'b1;
            d.st = SR_HI;
         end
         SR_HI:
         begin
            d.sck = 1'b0;
            d.st = SR_LO;
         end
         SR_LO:
         begin
            d.cnt = '0;
            d.st = SR_WAIT;
         end
         SR_WAIT:
         begin
            d.cnt = q.cnt + 3'h1;
            if (q.cnt == SER_WAIT)
            begin
               d.rx = sense;
               d.se_n = 1'b1;
               d.oe_n = 1'b1;
               d.st = SR_IDLE;
            end
         end
         default:
            d.st = SR_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         q <= '0;
         q.se_n <= 1'b1;
         q.oe_n <= 1'b1;
      end
      else
         q <= d;
   end

   assign serial_shift_clock = q.sck;
   assign serial_port_enable_n = q.se_n && !force_se_low;
   assign sdq_drv = q.drv;
   assign sdq_oe_n = q.oe_n;
   assign rx = q.rx;
   assign busy = (q.st != SR_IDLE);
endmodule

// File: vram_ctl.sv
// host controller driving a dual-port video dram from wishbone registers
`timescale 1ns/100ps
module vram_ctl (
   input  wire logic                       clk,
   input  wire logic                       sys_rst,
   input  wire logic                       wb_cyc,
   input  wire logic                       wb_stb,
   input  wire logic                       wb_we,
   input  wire logic [7:0]                 wb_adr,
   input  wire logic [3:0]                 wb_sel,
   input  wire logic [31:0]                wb_wdat,
   output logic      [31:0]                wb_rdat,
   output logic                            wb_ack,
   output logic                            ras_n,
   output logic                            cas_n,
   output logic                            we_n,
   output logic                            transfer_or_output_enable_n,
   output logic                            special_function_flag,
   output logic      [vram_ctl_pkg::AW-1:0] addr,
   output logic      [vram_ctl_pkg::DW-1:0] dq_drv,
   output logic                            dq_oe_n,
   input  wire logic [vram_ctl_pkg::DW-1:0] dq_sense,
   output logic                            serial_shift_clock,
   output logic                            serial_port_enable_n,
   output logic      [vram_ctl_pkg::DW-1:0] sdq_drv,
   output logic                            sdq_oe_n,
   input  wire logic [vram_ctl_pkg::DW-1:0] sdq_sense,
   input  wire logic                       serial_half_indicator
);
   import vram_ctl_pkg::*;

   typedef enum logic [3:0] {
      S_IDLE, S_SETUP, S_RAS, S_COL, S_CAS, S_WAIT, S_WR2, S_WE, S_END,
      S_OPEN, S_PRE
   } st_t;

   typedef struct packed {
      st_t           st;
      op_t           op;
      logic          keep;
      logic          pend;
      logic [AW-1:0] row;
      logic [AW-1:0] col;
      logic [DW-1:0] wdat;
      logic [DW-1:0] wmask;
      logic [DW-1:0] rdat;
      logic          err;
      logic          sdir;
      logic          ack;
      logic [31:0]   bus;
      logic [9:0]    rcnt;
      logic [2:0]    wcnt;
      logic          ras_n;
      logic          cas_n;
      logic          we_n;
      logic          dt_n;
      logic          flag;
      logic          se_lo;
      logic [AW-1:0] addr;
      logic [DW-1:0] dq;
      logic          dq_oe_n;
      logic          ser_go;
      logic [DW-1:0] ser_word;
      logic          ser_en;
   } state_t;

   state_t        q;
   state_t        d;
   logic [DW-1:0] dq_now;
   logic          half;
   logic          ser_busy;
   logic [DW-1:0] ser_rx;
   logic [3:0]    lv;
   logic [31:0]   rd;
   logic [31:0]   w;
   logic          wr;
   logic          busy;
   logic          xfer_low;

   vram_pin_sync #(.W(DW + 1)) u_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .pin     ({serial_half_indicator, dq_sense}),
      .level   ({half, dq_now})
   );

   vram_serial u_ser (
      .clk                  (clk),
      .sys_rst              (sys_rst),
      .go                   (q.ser_go),
      .word                 (q.ser_word),
      .en                   (q.ser_en),
      .host_drives          (q.sdir),
      .force_se_low         (q.se_lo),
      .sdq_sense            (sdq_sense),
      .serial_shift_clock   (serial_shift_clock),
      .serial_port_enable_n (serial_port_enable_n),
      .sdq_drv              (sdq_drv),
      .sdq_oe_n             (sdq_oe_n),
      .rx                   (ser_rx),
      .busy                 (ser_busy)
   );

   assign lv = ras_levels(q.op);
   assign busy = (q.st != S_IDLE) && (q.st != S_OPEN);
   assign xfer_low = is_xfer(q.op) && !q.ras_n;

   always_comb
   begin
      d = q;
      d.ack = wb_cyc && wb_stb && !q.ack;
      d.ser_go = 1'b0;
      wr = wb_cyc && wb_stb && q.ack && wb_we;
      rd = RST_ZERO;
      case (wb_adr)
         A_CMD:
         begin
            rd[3:0] = q.op;
            rd[CMD_KEEP] = q.keep;
         end
         A_ADDR:
         begin
            rd[AW-1:0] = q.row;
            rd[ADDR_COL +: AW] = q.col;
         end
         A_WDATA:
         begin
            rd[DW-1:0] = q.wdat;
            rd[WD_MASK +: DW] = q.wmask;
         end
         A_STAT:
         begin
            rd[DW-1:0] = q.rdat;
            rd[ST_BUSY] = busy || q.pend;
            rd[ST_OPEN] = (q.st == S_OPEN);
            rd[ST_SDIR] = q.sdir;
            rd[ST_HALF] = half;
            rd[ST_ERR] = q.err;
         end
         A_SER:
         begin
            rd[DW-1:0] = ser_rx;
            rd[SER_BUSY] = ser_busy;
         end
         default:
            rd = RST_ZERO;
      endcase
      if (d.ack)
         d.bus = rd;
      w = merge(rd, wb_wdat, wb_sel);
      if (wr && wb_adr == A_ADDR)
      begin
         d.row = w[AW-1:0];
         d.col = w[ADDR_COL +: AW];
      end
      if (wr && wb_adr == A_WDATA)
      begin
         d.wdat = w[DW-1:0];
         d.wmask = w[WD_MASK +: DW];
      end
      if (wr && wb_adr == A_STAT && w[ST_ERR])
         d.err = 1'b0;
      if (wr && wb_adr == A_SER && wb_sel[0])
      begin
         if (ser_busy || xfer_low)
            d.err = 1'b1;
         else
         begin
            d.ser_go = 1'b1;
            d.ser_word = w[DW-1:0];
            d.ser_en = w[SER_EN];
         end
      end
      if (wr && wb_adr == A_CMD && wb_sel[0])
      begin
         if (busy || q.pend || w[3:0] > 4'(OP_REFRESH))
            d.err = 1'b1;
         else
         begin
            d.op = op_t'(w[3:0]);
            d.keep = w[CMD_KEEP];
            if (q.st == S_IDLE)
               d.st = S_SETUP;
            else if (is_page(op_t'(w[3:0])))
               d.st = S_COL;
            else
            begin
               d.pend = 1'b1;
               d.st = S_PRE;
            end
         end
      end
      case (q.st)
         S_SETUP:
         begin
            d.addr = q.row;
            d.dt_n = lv[3];
            d.we_n = lv[2];
            d.se_lo = !lv[1];
            d.flag = lv[0];
            d.cas_n = !(q.op == OP_REFRESH);
            if (lv[3] && !lv[2])
            begin
               d.dq = q.wmask;
               d.dq_oe_n = 1'b0;
            end
            d.st = S_RAS;
         end
         S_RAS:
         begin
            d.ras_n = 1'b0;
            if (q.op == OP_REFRESH || q.op == OP_FLASH_WRITE)
               d.st = S_PRE;
            else
               d.st = S_COL;
         end
         S_COL:
         begin
            d.addr = q.col;
            d.flag = is_block(q.op);
            d.we_n = 1'b1;
            d.dq_oe_n = 1'b1;
            if (!is_rd(q.op) && !is_xfer(q.op))
            begin
               d.dt_n = 1'b1;
               d.we_n = 1'b0;
               d.dq = q.wdat;
               d.dq_oe_n = 1'b0;
            end
            d.st = S_CAS;
         end
         S_CAS:
         begin
            d.cas_n = 1'b0;
            d.wcnt = '0;
            if (is_rd(q.op))
            begin
               d.dt_n = 1'b0;
               d.st = S_WAIT;
            end
            else
               d.st = S_END;
         end
         S_WAIT:
         begin
            d.wcnt = q.wcnt + 3'h1;
            if (q.wcnt == READ_WAIT)
            begin
               d.rdat = dq_now;
               d.dt_n = 1'b1;
               d.st = (q.op == OP_RMW) ? S_WR2 : S_END;
            end
         end
         S_WR2:
         begin
            d.dq = q.wdat;
            d.dq_oe_n = 1'b0;
            d.st = S_WE;
         end
         S_WE:
         begin
            d.we_n = 1'b0;
            d.st = S_END;
         end
         S_END:
         begin
            d.cas_n = 1'b1;
            d.we_n = 1'b1;
            d.flag = 1'b0;
            d.dq_oe_n = 1'b1;
            d.st = (q.keep && is_page(q.op)) ? S_OPEN : S_PRE;
         end
         S_OPEN:
            if (q.rcnt >= ROW_LIMIT)
            begin
               // column command taken now reruns after precharge
               d.pend = d.pend || (d.st == S_COL);
               d.st = S_PRE;
            end
         S_PRE:
         begin
            d.ras_n = 1'b1;
            d.cas_n = 1'b1;
            d.we_n = 1'b1;
            d.dt_n = 1'b1;
            d.flag = 1'b0;
            d.se_lo = 1'b0;
            d.dq_oe_n = 1'b1;
            // pending op has not run yet, so no direction change
            if (q.pend)
               d.sdir = q.sdir;
            else if (q.op == OP_READ_XFER)
               d.sdir = 1'b0;
            else if (q.op == OP_WRITE_XFER || q.op == OP_PSEUDO_XFER)
               d.sdir = 1'b1;
            d.pend = 1'b0;
            d.st = q.pend ? S_SETUP : S_IDLE;
         end
         default:
            ;
      endcase
      if (wr && wb_adr == A_CMD && busy)
         d.err = 1'b1;
      d.rcnt = q.ras_n ? 10'h0 : q.rcnt + 10'h1;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         q <= '0;
         q.ras_n <= 1'b1;
         q.cas_n <= 1'b1;
         q.we_n <= 1'b1;
         q.dt_n <= 1'b1;
         q.dq_oe_n <= 1'b1;
      end
      else
         q <= d;
   end

   assign wb_rdat = q.bus;
   assign wb_ack = q.ack;
   assign ras_n = q.ras_n;
   assign cas_n = q.cas_n;
   assign we_n = q.we_n;
   assign transfer_or_output_enable_n = q.dt_n;
   assign special_function_flag = q.flag;
   assign addr = q.addr;
   assign dq_drv = q.dq;
   assign dq_oe_n = q.dq_oe_n;

   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   AST_ROW_AT_RAS: assert property ($fell(ras_n) |-> addr == q.row &&
      $stable(addr)) else $error("row address not held at row strobe");
   AST_COL_AT_CAS: assert property ($fell(cas_n) && !ras_n |->
      $stable(addr) && addr == q.col)
      else $error("column address not stable at column strobe");
   AST_READ_LEVELS: assert property ($fell(ras_n) && q.op == OP_READ
      |-> cas_n && transfer_or_output_enable_n && !special_function_flag)
      else $error("read levels wrong at row strobe");
   AST_READ_OE: assert property (q.st == S_WAIT |-> !cas_n && we_n &&
      !transfer_or_output_enable_n && dq_oe_n)
      else $error("read strobes wrong while waiting");
   AST_FLAG_RAS: assert property ($fell(ras_n) |->
      special_function_flag == (q.op inside {OP_COLOR_READ,
      OP_COLOR_WRITE, OP_FLASH_WRITE, OP_SPLIT_READ_XFER,
      OP_SPLIT_WRITE_XFER}))
      else $error("flag wrong at row strobe");
   AST_FLAG_CAS: assert property ($fell(cas_n) && !ras_n |->
      special_function_flag == (q.op inside {OP_BLOCK_WRITE,
      OP_MASK_BLOCK_WRITE}))
      else $error("flag wrong at column strobe");
   AST_COLOR: assert property ($fell(ras_n) &&
      (q.op == OP_COLOR_READ || q.op == OP_COLOR_WRITE) |->
      special_function_flag && transfer_or_output_enable_n && cas_n)
      else $error("color access levels wrong");
   AST_OE_WHILE_DRIVE: assert property (!dq_oe_n |->
      transfer_or_output_enable_n)
      else $error("data driven while output enable low");
   AST_RMW_ORDER: assert property ($fell(dq_oe_n) && q.op == OP_RMW
      |-> $past(transfer_or_output_enable_n) && we_n ##1 !we_n)
      else $error("read-modify-write order wrong");
   AST_ROW_TIME: assert property (q.rcnt < ROW_OPEN_CYC)
      else $error("row held open too long");

   COV_READ: cover property (q.st == S_WAIT && q.wcnt == READ_WAIT);
   COV_PAGE: cover property (q.st == S_OPEN ##1 q.st == S_COL);
   COV_RMW: cover property (q.st == S_WE);
   COV_SERIAL: cover property ($rose(serial_shift_clock));
endmodule

// File: vram_dev_model.sv
// behavioural video dram answering the controller's strobes
`timescale 1ns/100ps
module vram_dev_model (
   input  wire logic       ras_n,
   input  wire logic       cas_n,
   input  wire logic       we_n,
   input  wire logic       oe_n,
   input  wire logic       flag,
   input  wire logic [8:0] addr,
   input  wire logic [3:0] dq_drv,
   input  wire logic       dq_oe_n,
   output wire logic [3:0] dq,
   input  wire logic       sck,
   input  wire logic       se_n,
   input  wire logic [3:0] sdq_drv,
   input  wire logic       sdq_oe_n,
   output wire logic [3:0] sdq,
   output wire logic       half
);
   logic [3:0] mem[512];
   logic [3:0] sbuf[512];
   logic [3:0] color = 4'h0;
   logic [3:0] last = 4'h0;
   logic [3:0] sword = 4'h0;
   logic [3:0] wmask;
   logic [8:0] col;
   logic [8:0] ptr = 9'h0;
   logic       xfer = 1'b0;
   logic       colr = 1'b0;
   logic       blk = 1'b0;
   logic       sout = 1'b0;
   logic       wrx, pseudo, rd;
   initial
      foreach (mem[i])
      begin
         mem[i] = 4'h0;
         sbuf[i] = 4'h0;
      end
   // row not modelled: one row stands for all
   task automatic put(logic [8:0] a, logic [3:0] d);
      if (colr)
         color = d;
      else
         mem[a] = (mem[a] & ~wmask) | (d & wmask);
   endtask
   always @(negedge ras_n)
   begin
      xfer = cas_n && !oe_n;
      wrx = xfer && !we_n;
      pseudo = wrx && se_n && !flag;
      colr = cas_n && oe_n && flag;
      wmask = (we_n || xfer) ? 4'hF : dq;
      blk = 1'b0;
      if (colr && !we_n)
      begin
         colr = 1'b0;
         foreach (mem[i])
            put(9'(i), color);
      end
   end
   always @(negedge cas_n)
      if (!ras_n)
      begin
         col = addr;
         blk = flag && !xfer && !colr;
         for (int i = 0; i < 4; i++)
            if (blk && dq[i])
               put({col[8:2], 2'(i)}, color);
         if (!blk && !xfer && !we_n)
            put(col, dq);
      end
   always @(negedge we_n)
      if (!ras_n && !cas_n && !xfer)
         put(col, dq);
   always @(posedge ras_n)
      if (xfer)
      begin
         ptr = col;
         sout = !wrx;
         foreach (mem[i])
            if (!wrx)
               sbuf[i] = mem[i];
            else if (!pseudo)
               mem[i] = sbuf[i];
      end
   assign rd = !ras_n && !cas_n && we_n && !oe_n && !xfer && !blk;
   assign dq = !dq_oe_n ? dq_drv : rd ? (colr ? color : mem[col]) : ~last;
   always @(dq)
      if (!dq_oe_n || rd)
         last = dq;
   always @(posedge sck)
   begin
      if (!se_n && !sout)
         sbuf[ptr] = sdq;
      sword = sbuf[ptr];
      ptr = ptr + 9'h1;
   end
   assign half = ptr[8];
   assign sdq = !sdq_oe_n ? sdq_drv : (sout && !se_n) ? sword : ~sword;
endmodule

// File: vram_ctl_test.sv
// self-checking bench for the video dram controller
`timescale 1ns/100ps
module vram_ctl_test;
   import vram_ctl_pkg::*;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        wb_cyc = 1'b0;
   logic        wb_stb = 1'b0;
   logic        wb_we = 1'b0;
   logic [7:0]  wb_adr = 8'h0;
   logic [31:0] wb_wdat = 32'h0;
   logic [3:0]  wb_sel = 4'hF;
   logic        keep = 1'b0;
   logic [31:0] wb_rdat;
   logic        wb_ack, ras_n, cas_n, we_n, oe_n, flag, dq_oe_n, sck, se_n;
   logic        sdq_oe_n, half;
   logic [8:0]  addr;
   logic [3:0]  dq_drv, dq, sdq_drv, sdq;
   int          num_errors = 0;
   int          comparisons = 0;
   int          cycles = 0;
   vram_ctl uut (.clk(clk), .sys_rst(sys_rst), .wb_cyc(wb_cyc),
      .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
      .wb_wdat(wb_wdat), .wb_rdat(wb_rdat), .wb_ack(wb_ack), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .transfer_or_output_enable_n(oe_n),
      .special_function_flag(flag), .addr(addr), .dq_drv(dq_drv),
      .dq_oe_n(dq_oe_n), .dq_sense(dq), .serial_shift_clock(sck),
      .serial_port_enable_n(se_n), .sdq_drv(sdq_drv), .sdq_oe_n(sdq_oe_n),
      .sdq_sense(sdq), .serial_half_indicator(half));
   vram_dev_model dev (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
      .oe_n(oe_n), .flag(flag), .addr(addr), .dq_drv(dq_drv),
      .dq_oe_n(dq_oe_n), .dq(dq), .sck(sck), .se_n(se_n),
      .sdq_drv(sdq_drv), .sdq_oe_n(sdq_oe_n), .sdq(sdq), .half(half));
   initial
      forever
         #50 clk = ~clk;
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         num_errors++;
         give_verdict();
      end
   end
   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wb(logic w, logic [7:0] a, logic [31:0] d,
                     output logic [31:0] q);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_wdat <= d;
      @(posedge clk);
      while (wb_ack !== 1'b1)
         @(posedge clk);
      q = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic op(op_t c, logic [8:0] r, logic [8:0] col, logic [7:0] d,
                     output logic [31:0] q);
      wb(1'b1, A_ADDR, {7'h0, col, 7'h0, r}, q);
      wb(1'b1, A_WDATA, {24'h0, d}, q);
      wb(1'b1, A_CMD, {27'h0, keep, c}, q);
      do
         wb(1'b0, A_STAT, 32'h0, q);
      while (q[ST_BUSY] !== 1'b0);
   endtask
   task automatic ser(logic [7:0] d, output logic [31:0] q);
      wb(1'b1, A_SER, {24'h0, d}, q);
      do
         wb(1'b0, A_SER, 32'h0, q);
      while (q[SER_BUSY] !== 1'b0);
   endtask
   task automatic t_ram;
      logic [31:0] q;
      wb(1'b0, 8'h20, 32'h0, q);
      chk("unmapped", q, 32'h0);
      op(OP_COLOR_WRITE, 9'h3, 9'h0, 8'h05, q);
      op(OP_COLOR_READ, 9'h3, 9'h0, 8'h00, q);
      chk("color", q[3:0], 4'h5);
      op(OP_WRITE, 9'h1, 9'h1A3, 8'h0C, q);
      op(OP_READ, 9'h1, 9'h1A3, 8'h00, q);
      chk("read", q[3:0], 4'hC);
      op(OP_MASK_WRITE, 9'h1, 9'h1A3, 8'h31, q);
      op(OP_READ, 9'h1, 9'h1A3, 8'h00, q);
      chk("mask", q[3:0], 4'hD);
      op(OP_RMW, 9'h1, 9'h1A3, 8'h09, q);
      chk("rmw old", q[3:0], 4'hD);
      $display("ram test done");
   endtask
   task automatic t_fill;
      logic [31:0] q;
      logic [3:0]  exp[4] = '{4'h5, 4'h0, 4'h5, 4'h9};
      op(OP_BLOCK_WRITE, 9'h1, 9'h1A1, 8'h05, q);
      for (int i = 0; i < 4; i++)
      begin
         op(OP_READ, 9'h1, 9'h1A0 + 9'(i), 8'h00, q);
         chk("block", q[3:0], exp[i]);
      end
      op(OP_FLASH_WRITE, 9'h1, 9'h0, 8'h80, q);
      op(OP_READ, 9'h1, 9'h1A3, 8'h00, q);
      chk("flash", q[3:0], 4'h1);
      $display("fill test done");
   endtask
   task automatic t_serial;
      logic [31:0] q;
      op(OP_WRITE, 9'h1, 9'h0FF, 8'h0A, q);
      op(OP_READ_XFER, 9'h1, 9'h0FF, 8'h00, q);
      chk("dir out", q[ST_SDIR], 1'b0);
      chk("half low", q[ST_HALF], 1'b0);
      ser(8'h10, q);
      chk("word", q[3:0], 4'hA);
      wb(1'b0, A_STAT, 32'h0, q);
      chk("half high", q[ST_HALF], 1'b1);
      op(OP_PSEUDO_XFER, 9'h1, 9'h020, 8'h00, q);
      chk("dir in", q[ST_SDIR], 1'b1);
      ser(8'h16, q);
      ser(8'h09, q);
      op(OP_WRITE_XFER, 9'h1, 9'h020, 8'h00, q);
      op(OP_READ, 9'h1, 9'h020, 8'h00, q);
      chk("wxfer", q[3:0], 4'h6);
      op(OP_READ, 9'h1, 9'h021, 8'h00, q);
      chk("masked", q[3:0], 4'h0);
      wb(1'b1, A_CMD, 32'h0F, q);
      wb(1'b0, A_STAT, 32'h0, q);
      chk("err", q[ST_ERR], 1'b1);
      wb_sel <= 4'hC;
      wb(1'b1, A_ADDR, 32'h01FF_01FF, q);
      wb_sel <= 4'hF;
      wb(1'b0, A_ADDR, 32'h0, q);
      chk("lanes", q, 32'h01FF_0001);
      $display("serial test done");
   endtask
   task automatic t_page;
      logic [31:0] q;
      int          n = 0;
      keep = 1'b1;
      op(OP_WRITE, 9'h2, 9'h040, 8'h03, q);
      chk("open", q[ST_OPEN], 1'b1);
      op(OP_READ, 9'h2, 9'h040, 8'h00, q);
      chk("page read", q[3:0], 4'h3);
      do
      begin
         wb(1'b0, A_STAT, 32'h0, q);
         n++;
      end
      while (q[ST_OPEN] === 1'b1 && n < 1000);
      chk("row held", 32'(n > ROW_LIMIT / 4), 32'h1);
      chk("row closed", q[ST_OPEN], 1'b0);
      op(OP_WRITE, 9'h2, 9'h041, 8'h05, q);
      keep = 1'b0;
      op(OP_REFRESH, 9'h2, 9'h000, 8'h00, q);
      chk("pend closed", q[ST_OPEN], 1'b0);
      op(OP_READ, 9'h2, 9'h041, 8'h00, q);
      chk("after refresh", q[3:0], 4'h5);
      $display("page test done");
   endtask
   initial
   begin
      repeat (16)
         @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_ram();
      t_fill();
      t_serial();
      t_page();
      give_verdict();
   end
endmodule
